// ### logic/dcef_consts.vh
`ifndef DCEF_CONSTS_VH
`define DCEF_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DCEF_OFF_BUFFER_CFG 8'h00
`define DCEF_OFF_READ_OFFSET 8'h04
`define DCEF_OFF_SYNC_SOURCE 8'h08
`define DCEF_OFF_ALARM_STATUS 8'h0C
`define DCEF_OFF_ALARM_ROUTE 8'h10
`define DCEF_OFF_INTERP 8'h14
`define DCEF_OFF_POINTERS 8'h18

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DCEF_BIT_BUF_ENA 0
`define DCEF_BIT_WR_RST_ENA 1
`define DCEF_BIT_RD_RST_ENA 2
`define DCEF_BIT_SYNC_SINGLE 0
`define DCEF_BIT_ALM_COLL 0
`define DCEF_BIT_ALM_ONE 1
`define DCEF_BIT_ALM_TWO 2
`define DCEF_BIT_RD_PTR_LSB 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DCEF_RST_BUFFER_CFG 3'h7
`define DCEF_RST_READ_OFFSET 3'h4
`define DCEF_RST_SYNC_SOURCE 1'h0
`define DCEF_RST_ALARM_ROUTE 3'h7
`define DCEF_RST_INTERP 4'h2
`define DCEF_WR_PTR_START 3'h0

// ----------------------------------------
// Buffer geometry
// ----------------------------------------
`define DCEF_DEPTH 8
`define DCEF_PTR_W 3
`define DCEF_LANE_W 16
`define DCEF_BYTES_PER_SAMPLE 4

`endif

// ### logic/dcef_mem.v
`timescale 1ns/1ps
`default_nettype none

// Sample store: one write port, registered read port
module dcef_mem #(
   parameter DATA_W = 32,
   parameter ADDR_W = 3,
   parameter DEPTH = 8
) (
   // Clock
   input wire clk_i,
   // Write port
   input wire wr_en_i,
   input wire [ADDR_W-1:0] wr_addr_i,
   input wire [DATA_W-1:0] wr_data_i,
   // Read port
   input wire rd_en_i,
   input wire [ADDR_W-1:0] rd_addr_i,
   output reg [DATA_W-1:0] rd_data_o
);

   reg [DATA_W-1:0] mem_reg [0:DEPTH-1];

   always @(posedge clk_i) begin
      if (wr_en_i) begin
         mem_reg[wr_addr_i] <= wr_data_i;
      end
   end

   // Same-address read and write returns the old entry
   always @(posedge clk_i) begin
      if (rd_en_i) begin
         rd_data_o <= mem_reg[rd_addr_i];
      end
   end

endmodule // dcef_mem

`default_nettype wire

// ### logic/dcef_elastic_fifo.v
`timescale 1ns/1ps
`default_nettype none
`include "dcef_consts.vh"

module dcef_elastic_fifo #(
   parameter INTERP_W = 4
) (
   // Clock and reset
   input wire clk_i,
   input wire sys_rst_i,
   // Register port
   input wire [7:0] reg_addr_i,
   input wire [31:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [31:0] reg_rdata_o,
   // Source link, sampled levels
   input wire input_word_clock_i,
   input wire [7:0] data_byte_i,
   input wire frame_i,
   input wire output_sync_strobe_i,
   // Conversion side
   output reg [15:0] sample_i_o,
   output reg [15:0] sample_q_o,
   output reg sample_valid_o,
   output wire alarm_out_pin_o
);

   localparam PW = `DCEF_PTR_W;
   localparam DW = 2 * `DCEF_LANE_W;

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   reg [2:0] buffer_cfg_reg;
   reg [2:0] read_offset_cfg_reg;
   reg sync_source_cfg_reg;
   reg [2:0] alarm_status_reg;
   reg [2:0] alarm_route_reg;
   reg [INTERP_W-1:0] interp_reg;

   wire buf_ena = buffer_cfg_reg[`DCEF_BIT_BUF_ENA];
   wire wr_rst_ena = buffer_cfg_reg[`DCEF_BIT_WR_RST_ENA];
   wire rd_rst_ena = buffer_cfg_reg[`DCEF_BIT_RD_RST_ENA];
   wire single_src = sync_source_cfg_reg;

   wire wr_hit = reg_wr_i;
   wire [2:0] alarm_now;

   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         buffer_cfg_reg <= `DCEF_RST_BUFFER_CFG;
         read_offset_cfg_reg <= `DCEF_RST_READ_OFFSET;
         sync_source_cfg_reg <= `DCEF_RST_SYNC_SOURCE;
         alarm_route_reg <= `DCEF_RST_ALARM_ROUTE;
         interp_reg <= `DCEF_RST_INTERP;
      end else if (wr_hit) begin
         case (reg_addr_i)
            `DCEF_OFF_BUFFER_CFG: begin
               buffer_cfg_reg <= reg_wdata_i[2:0];
            end
            `DCEF_OFF_READ_OFFSET: begin
               read_offset_cfg_reg <= reg_wdata_i[2:0];
            end
            `DCEF_OFF_SYNC_SOURCE: begin
               sync_source_cfg_reg <= reg_wdata_i[`DCEF_BIT_SYNC_SINGLE];
            end
            `DCEF_OFF_ALARM_ROUTE: begin
               alarm_route_reg <= reg_wdata_i[2:0];
            end
            `DCEF_OFF_INTERP: begin
               interp_reg <= reg_wdata_i[INTERP_W-1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------
   // Sticky alarm status
   // ----------------------------------------
   // Write one to clear; a live condition wins over the clear
   wire [2:0] alarm_clr = (wr_hit && reg_addr_i == `DCEF_OFF_ALARM_STATUS) ?
                          reg_wdata_i[2:0] : 3'h0;

   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         alarm_status_reg <= 3'h0;
      end else begin
         alarm_status_reg <= (alarm_status_reg & ~alarm_clr) | alarm_now;
      end
   end

   // ----------------------------------------
   // Register read
   // ----------------------------------------
   reg [PW-1:0] wr_ptr_reg;
   reg [PW-1:0] rd_ptr_reg;

   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= 32'h0;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            `DCEF_OFF_BUFFER_CFG: reg_rdata_o <= {29'h0, buffer_cfg_reg};
            `DCEF_OFF_READ_OFFSET: reg_rdata_o <= {29'h0, read_offset_cfg_reg};
            `DCEF_OFF_SYNC_SOURCE: reg_rdata_o <= {31'h0, sync_source_cfg_reg};
            `DCEF_OFF_ALARM_STATUS: reg_rdata_o <= {29'h0, alarm_status_reg};
            `DCEF_OFF_ALARM_ROUTE: reg_rdata_o <= {29'h0, alarm_route_reg};
            `DCEF_OFF_INTERP: reg_rdata_o <= {{(32-INTERP_W){1'b0}}, interp_reg};
            `DCEF_OFF_POINTERS: reg_rdata_o <= {25'h0, rd_ptr_reg, 1'b0, wr_ptr_reg};
            default: reg_rdata_o <= 32'h0;
         endcase
      end else begin
         reg_rdata_o <= 32'h0;
      end
   end

   // ----------------------------------------
   // Word clock edge detection
   // ----------------------------------------
   // Inputs are synchronous to clk_i, so one history flop is enough
   reg wclk_prev_reg;
   reg frame_prev_reg;

   wire wclk_rise = input_word_clock_i & ~wclk_prev_reg;
   wire wclk_fall = ~input_word_clock_i & wclk_prev_reg;
   wire byte_stb = wclk_rise | wclk_fall;
   wire frame_rise = wclk_rise & frame_i & ~frame_prev_reg;

   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         wclk_prev_reg <= 1'b0;
         frame_prev_reg <= 1'b0;
      end else begin
         wclk_prev_reg <= input_word_clock_i;
         if (wclk_rise) begin
            frame_prev_reg <= frame_i;
         end
      end
   end

   // ----------------------------------------
   // Byte packing
   // ----------------------------------------
   // First byte of a sample is I high byte; frame rise marks it
   reg [1:0] byte_cnt_reg;
   reg [23:0] byte_acc_reg;
   reg [DW-1:0] packed_reg;
   reg packed_stb_reg;

   wire [1:0] byte_pos = frame_rise ? 2'h0 : byte_cnt_reg;

   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         byte_cnt_reg <= 2'h0;
         byte_acc_reg <= 24'h0;
         packed_reg <= {DW{1'b0}};
         packed_stb_reg <= 1'b0;
      end else begin
         packed_stb_reg <= 1'b0;
         if (byte_stb) begin
            byte_cnt_reg <= byte_pos + 2'h1;
            byte_acc_reg <= {byte_acc_reg[15:0], data_byte_i};
            if (byte_pos == 2'h3) begin
               packed_reg <= {byte_acc_reg, data_byte_i};
               packed_stb_reg <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // Read tick divider
   // ----------------------------------------
   // Factor of zero is taken as one
   reg [INTERP_W-1:0] div_cnt_reg;
   wire [INTERP_W-1:0] div_last = (interp_reg == {INTERP_W{1'b0}}) ?
                                  {INTERP_W{1'b0}} : interp_reg - 1'b1;
   wire rd_tick = (div_cnt_reg == {INTERP_W{1'b0}});

   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         div_cnt_reg <= {INTERP_W{1'b0}};
      end else if (div_cnt_reg >= div_last) begin
         div_cnt_reg <= {INTERP_W{1'b0}};
      end else begin
         div_cnt_reg <= div_cnt_reg + 1'b1;
      end
   end

   // ----------------------------------------
   // Reset sources
   // ----------------------------------------
   reg osync_prev_reg;
   reg frame_sync1_reg;
   reg frame_sync2_reg;
   reg frame_pend_reg;

   wire osync_rise = output_sync_strobe_i & ~osync_prev_reg;
   wire wr_ptr_rst = frame_rise & wr_rst_ena;
   // Frame path costs a few cycles of phase, hence dual mode
   wire rd_frame_rst = frame_pend_reg & rd_tick & rd_rst_ena & single_src;
   wire rd_osync_rst = osync_rise & rd_rst_ena & ~single_src;
   wire rd_ptr_rst = rd_frame_rst | rd_osync_rst;

   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         osync_prev_reg <= 1'b0;
         frame_sync1_reg <= 1'b0;
         frame_sync2_reg <= 1'b0;
         frame_pend_reg <= 1'b0;
      end else begin
         osync_prev_reg <= output_sync_strobe_i;
         frame_sync1_reg <= frame_rise;
         frame_sync2_reg <= frame_sync1_reg;
         if (frame_sync2_reg) begin
            frame_pend_reg <= 1'b1;
         end else if (rd_tick) begin
            frame_pend_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Pointers
   // ----------------------------------------
   // Both wrap over eight entries, so one reset serves forever
   wire wr_en = packed_stb_reg & buf_ena;
   wire rd_en = rd_tick & buf_ena;

   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         wr_ptr_reg <= `DCEF_WR_PTR_START;
         rd_ptr_reg <= `DCEF_RST_READ_OFFSET;
      end else begin
         if (wr_ptr_rst) begin
            wr_ptr_reg <= `DCEF_WR_PTR_START;
         end else if (wr_en) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (rd_ptr_rst) begin
            rd_ptr_reg <= read_offset_cfg_reg;
         end else if (rd_en) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Sample store
   // ----------------------------------------
   wire [DW-1:0] mem_rd_data;

   dcef_mem #(
      .DATA_W(DW),
      .ADDR_W(PW),
      .DEPTH(`DCEF_DEPTH)
   ) u_mem (
      .clk_i(clk_i),
      .wr_en_i(wr_en),
      .wr_addr_i(wr_ptr_reg),
      .wr_data_i(packed_reg),
      .rd_en_i(rd_en),
      .rd_addr_i(rd_ptr_reg),
      .rd_data_o(mem_rd_data)
   );

   // ----------------------------------------
   // Output stage
   // ----------------------------------------
   reg rd_en_d_reg;
   reg byp_d_reg;

   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         rd_en_d_reg <= 1'b0;
         byp_d_reg <= 1'b0;
         sample_i_o <= 16'h0;
         sample_q_o <= 16'h0;
         sample_valid_o <= 1'b0;
      end else begin
         rd_en_d_reg <= rd_en;
         byp_d_reg <= rd_tick & ~buf_ena;
         sample_valid_o <= 1'b0;
         if (rd_en_d_reg) begin
            sample_i_o <= mem_rd_data[31:16];
            sample_q_o <= mem_rd_data[15:0];
            sample_valid_o <= 1'b1;
         end else if (byp_d_reg) begin
            // No elasticity here: source must be phase-aligned
            sample_i_o <= packed_reg[31:16];
            sample_q_o <= packed_reg[15:0];
            sample_valid_o <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Pointer distance alarms
   // ----------------------------------------
   // Combinational from pointers, no clock in the comparison
   wire [PW-1:0] gap = wr_ptr_reg - rd_ptr_reg;

   assign alarm_now[`DCEF_BIT_ALM_COLL] = buf_ena & (gap == 3'h0);
   assign alarm_now[`DCEF_BIT_ALM_ONE] = buf_ena &
                                         (gap <= 3'h1 || gap == 3'h7);
   assign alarm_now[`DCEF_BIT_ALM_TWO] = buf_ena &
                                         (gap <= 3'h2 || gap >= 3'h6);

   // Live alarms reach the pin without waiting for status
   assign alarm_out_pin_o = |(alarm_route_reg & (alarm_now | alarm_status_reg));

endmodule // dcef_elastic_fifo

`default_nettype wire

// ### dv/dcef_elastic_fifo_checker.sv
`timescale 1ns/1ps
`default_nettype none
module dcef_elastic_fifo_checker (
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Watched ports
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic [15:0] sample_i_o,
   input wire logic sample_valid_o,
   input wire logic alarm_out_pin_o
);
   // ----
   // Properties
   // ----
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence s_rd(logic [7:0] a);
      reg_rd_i && reg_addr_i == a;
   endsequence
   a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
      else $error("read data not idle");
   a_unmapped_zero: assert property (reg_rd_i && reg_addr_i > 8'h18 |=> reg_rdata_o == 32'h0)
      else $error("unmapped read not zero");
   a_offset_width: assert property (s_rd(8'h04) |=> reg_rdata_o[31:3] == 29'h0)
      else $error("offset field too wide");
   a_sync_width: assert property (s_rd(8'h08) |=> reg_rdata_o[31:1] == 31'h0)
      else $error("sync select too wide");
   a_status_width: assert property (s_rd(8'h0C) |=> reg_rdata_o[31:3] == 29'h0)
      else $error("status has stray bits");
   a_ptr_fields: assert property (s_rd(8'h18) |=> reg_rdata_o[31:7] == 25'h0 && !reg_rdata_o[3])
      else $error("pointer read has stray bits");
   // Bench keeps interp at two or more, so ticks never abut
   a_valid_pulse: assert property (sample_valid_o |=> !sample_valid_o)
      else $error("valid longer than one cycle");
   a_sample_hold: assert property ($changed(sample_i_o) |-> sample_valid_o)
      else $error("sample moved without valid");
   a_gap_quiet: assert property ($fell(sys_rst_i) |-> !alarm_out_pin_o)
      else $error("alarm after pointer reset");
endmodule // dcef_elastic_fifo_checker
`default_nettype wire

// ### dv/dcef_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcef_source_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Control
   input wire logic run_i,
   // Link
   output logic input_word_clock_o,
   output logic [7:0] data_byte_o,
   output logic frame_o
);
   // ----
   // Byte source
   // ----
   logic [7:0] cnt_reg;
   initial begin
      input_word_clock_o = 1'b0;
      data_byte_o = 8'h00;
   end
   always @(posedge clk_i) begin
      if (sys_rst_i || !run_i) begin
         cnt_reg <= 8'h00;
         frame_o <= 1'b0;
         // Idle bus must not keep the last byte
         data_byte_o <= ~data_byte_o;
      end else begin
         input_word_clock_o <= ~input_word_clock_o;
         data_byte_o <= cnt_reg;
         cnt_reg <= cnt_reg + 8'h01;
         // Every 256 bytes: a multiple of eight samples
         frame_o <= !input_word_clock_o && cnt_reg == 8'h00;
      end
   end
endmodule // dcef_source_model
`default_nettype wire

// ### dv/dcef_elastic_fifo_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dcef_elastic_fifo_tb;
   localparam logic [47:0] RST_ADR = 48'h00040810141C;
   localparam logic [23:0] RST_VAL = 24'h740720;
   logic clk_i, sys_rst_i, reg_wr_i, reg_rd_i, run, osync;
   logic [7:0] reg_addr_i;
   logic [31:0] reg_wdata_i;
   wire [31:0] reg_rdata_o;
   wire [15:0] sample_i_o, sample_q_o;
   wire sample_valid_o, alarm_out_pin_o, wclk, frame;
   wire [7:0] dbyte;
   int errors, n_checks;
   dcef_elastic_fifo dcef_elastic_fifo_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .input_word_clock_i(wclk),
      .data_byte_i(dbyte), .frame_i(frame), .output_sync_strobe_i(osync),
      .sample_i_o(sample_i_o), .sample_q_o(sample_q_o), .sample_valid_o(sample_valid_o),
      .alarm_out_pin_o(alarm_out_pin_o));
   dcef_source_model dcef_source_model_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .run_i(run), .input_word_clock_o(wclk), .data_byte_o(dbyte), .frame_o(frame));
   // ----
   // Helpers
   // ----
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task finish_test;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task wait_clk(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1 d = reg_rdata_o;
   endtask
   task pulse_osync;
      @(posedge clk_i);
      osync <= 1'b1;
      @(posedge clk_i);
      osync <= 1'b0;
   endtask
   // Source sends n bytes; n even so the word clock ends low
   task run_src(input int n);
      @(posedge clk_i);
      run <= 1'b1;
      wait_clk(n);
      run <= 1'b0;
      wait_clk(4);
   endtask
   // Read pointer moves on its own, so one step of slack
   task chk_ptr(input logic [2:0] wr, input logic [2:0] rd, input logic use_rd);
      logic [31:0] v;
      logic [2:0] d;
      rd_reg(8'h18, v);
      d = v[6:4] - rd;
      check(v[2:0], wr);
      if (use_rd) check(d[2:1], 2'b00);
   endtask
   task get_sample(output logic [31:0] s);
      int k;
      k = 0;
      do begin
         @(posedge clk_i);
         #1 k++;
      end while (sample_valid_o !== 1'b1 && k < 40);
      s = {sample_i_o, sample_q_o};
      if (k >= 40) begin
         errors++;
         finish_test();
      end
   endtask
   // ----
   // Scenarios
   // ----
   task t_reset;
      logic [31:0] v;
      chk_ptr(3'h0, 3'h4, 1'b1);
      for (int i = 0; i < 6; i++) begin
         rd_reg(RST_ADR[40-8*i +: 8], v);
         check(v, RST_VAL[20-4*i +: 4]);
      end
      $display("reset values done");
   endtask
   task t_write;
      logic [31:0] s;
      wr_reg(8'h14, 32'hF);
      run_src(12);
      chk_ptr(3'h3, 3'h0, 1'b0);
      run_src(4);
      chk_ptr(3'h1, 3'h0, 1'b0);
      wr_reg(8'h00, 32'h1);
      run_src(4);
      chk_ptr(3'h2, 3'h0, 1'b0);
      wr_reg(8'h00, 32'h0);
      run_src(4);
      chk_ptr(3'h2, 3'h0, 1'b0);
      // Last frame sent bytes 00..03, I high byte first
      get_sample(s);
      check(s, 32'h00010203);
      wr_reg(8'h00, 32'h7);
      $display("write pointer done");
   endtask
   task t_osync;
      for (int off = 0; off < 8; off++) begin
         wr_reg(8'h04, off);
         pulse_osync();
         chk_ptr(3'h2, off[2:0], 1'b1);
      end
      $display("output sync done");
   endtask
   task t_alarm;
      logic [31:0] v;
      wr_reg(8'h04, 32'h6);
      pulse_osync();
      wr_reg(8'h0C, 32'h7);
      rd_reg(8'h0C, v);
      check(v, 32'h0);
      check(alarm_out_pin_o, 1'b0);
      wait_clk(130);
      rd_reg(8'h0C, v);
      check(v[0], 1'b1);
      check(v[1], 1'b1);
      check(v[2], 1'b1);
      check(alarm_out_pin_o, 1'b1);
      wr_reg(8'h10, 32'h0);
      #1 check(alarm_out_pin_o, 1'b0);
      wr_reg(8'h10, 32'h7);
      $display("alarms done");
   endtask
   task t_single;
      wr_reg(8'h08, 32'h1);
      wr_reg(8'h04, 32'h3);
      run_src(4);
      wait_clk(14);
      chk_ptr(3'h1, 3'h3, 1'b1);
      $display("single source done");
   endtask
   task t_stream;
      logic [31:0] s, p;
      wr_reg(8'h08, 32'h0);
      wr_reg(8'h04, 32'h4);
      wr_reg(8'h14, 32'h4);
      @(posedge clk_i);
      run <= 1'b1;
      // One strobe only: the limit case of a long repeat period
      osync <= 1'b1;
      @(posedge clk_i);
      osync <= 1'b0;
      for (int n = 0; n < 24; n++) begin
         get_sample(s);
         if (n > 10) begin
            check(s[23:16], {s[31:24] + 8'h01});
            check(s[15:0], {s[31:24] + 8'h02, s[31:24] + 8'h03});
            check(s[31:24], {p[31:24] + 8'h04});
         end
         p = s;
      end
      wr_reg(8'h0C, 32'h7);
      rd_reg(8'h0C, s);
      check(s, 32'h0);
      @(posedge clk_i);
      run <= 1'b0;
      $display("stream done");
   endtask
   // ----
   // Main sequence
   // ----
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   initial begin
      sys_rst_i = 1'b1;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      reg_addr_i = 8'h00;
      reg_wdata_i = 32'h0;
      run = 1'b0;
      osync = 1'b0;
      errors = 0;
      n_checks = 0;
      wait_clk(10);
      sys_rst_i <= 1'b0;
      t_reset();
      t_write();
      t_osync();
      t_alarm();
      t_single();
      t_stream();
      finish_test();
   end
endmodule // dcef_elastic_fifo_tb
bind dcef_elastic_fifo dcef_elastic_fifo_checker dcef_elastic_fifo_checker_inst (
   .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .sample_i_o(sample_i_o), .sample_valid_o(sample_valid_o),
   .alarm_out_pin_o(alarm_out_pin_o));
`default_nettype wire
